// ### rtl/pwm_cfg_consts.svh
// register offsets, reset values, field positions and timing counts for the config bank
// assumes inclusion from the two design files by bare name; the package does not include it
//
// Operation
// [R1] deadtime limit register resets to 56 ns each direction
// [R2] deadtime bounds apply in fixed and adaptive modes, clamped to 60 ns
// [R3] bits 14..8 give signed max high-to-low deadtime in ns
// [R4] bits 6..0 give signed max low-to-high deadtime in ns
// [R5] bits 15..11 of maker config set blanking delay in 32 ns steps
// [R6] current-sense fault only after 2C+1 consecutive violations
// [R7] maker bit 7 enables external temperature measurements
// [R8] maker bit 6 picks external sensor; software also sets bit 7
// [R9] bits 5..4 choose current-sense method; code 11 reserved
// [R10] bits 1 and 0 pick push-pull or open-drain for power-good and sync
// [R11] with user bit 13 set, ramp duty floor is (N+1)/256
// [R12] user bit 11 stops sync output 500 ms after disable
// [R13] user bit 9 low applies feed-forward correction to coefficients
// [R14] user bit 8 chooses fault spreading mode
// [R15] user bit 6 picks sync source, bit 5 sync pin direction
// [R16] user bit 2 holds low-side drive on while disabled
// [R17] user bits 1..0 pick standby mode; code 10 reserved
// [R18] reserved bits read zero and ignore writes; user config reset sets reserved bit 4, which reads 1 until written
// [R19] registers update only after a complete word write
`ifndef PWM_CFG_CONSTS_SVH
`define PWM_CFG_CONSTS_SVH

`define CMD_DEADTIME_LIMIT 8'hBF
`define CMD_MAKER_CONFIG 8'hD0
`define CMD_USER_CONFIG 8'hD1

`define RST_DEADTIME_LIMIT 16'h3838
`define RST_MAKER_CONFIG 16'h6A11
`define RST_USER_CONFIG 16'h2011

`define MASK_DEADTIME_LIMIT 16'h7F7F
`define MASK_MAKER_CONFIG 16'hFFFF
`define MASK_USER_CONFIG 16'hEB67

`define DEADTIME_RANGE_NS 7'h3C
`define BLANK_STEP_NS 32
`define SYNC_TIMEOUT_MS 500
`define CLOCK_MHZ 100
`define SYNC_TIMEOUT_CYC (`SYNC_TIMEOUT_MS * 1000 * `CLOCK_MHZ)

`endif

// ### rtl/pwm_cfg_pkg.sv
// types shared by the config bank and its word receiver
// assumes nothing from the constants header, which it does not include
package pwm_cfg_pkg;

  // one management-bus word transaction presented to the bank
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } word_xfer_s;

  typedef enum logic [1:0] {
    SENSE_GND_DOWN,
    SENSE_OUT_DOWN,
    SENSE_OUT_UP,
    SENSE_RSVD
  } sense_mode_e;

  typedef enum logic [1:0] {
    STBY_LOW_POWER,
    STBY_MONITOR,
    STBY_RSVD,
    STBY_PULSED
  } standby_mode_e;

  // decoded configuration handed to the power stage
  typedef struct packed {
    logic [6:0] dt_max_hl;
    logic [6:0] dt_max_lh;
    logic [9:0] blank_ns;
    logic [3:0] fault_count;
    logic ext_temp_en;
    logic ext_temp_sel;
    sense_mode_e sense_mode;
    logic nonlinear_response_always;
    logic alt_ramp_en;
    logic min_duty_en;
    logic [2:0] min_duty_num;
    logic ff_correct;
    logic spread_immediate;
    logic sync_external;
    logic sync_drive_out;
    logic low_side_on_disabled;
    standby_mode_e standby_mode;
  } cfg_s;

endpackage

// ### rtl/word_receiver.sv
// collects a command byte and two data bytes into one word write
// assumes byte strobes come from the serial engine on clock_i; abort drops partials
`timescale 1ns/100ps
`include "pwm_cfg_consts.svh"
module word_receiver
  import pwm_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic frame_start_i,
  input wire logic frame_abort_i,
  output word_xfer_s xfer_o,
  output logic xfer_valid_o
);

  typedef enum logic [1:0] {WAIT_CMD, WAIT_LO, WAIT_HI, IDLE_END} rx_state_e;

  rx_state_e state_r, state_nxt;
  word_xfer_s hold_r, hold_nxt;
  logic valid_r, valid_nxt;

  ////////////////////////////////////////////////////////////////////////
  // byte sequencing; low byte first as on the wire
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    valid_nxt = 1'b0;
    if (frame_abort_i || frame_start_i) begin
      state_nxt = WAIT_CMD; // partial word dropped [R19]
    end else if (byte_valid_i) begin
      unique case (state_r)
        WAIT_CMD: begin
          hold_nxt.cmd = byte_i;
          state_nxt = WAIT_LO;
        end
        WAIT_LO: begin
          hold_nxt.data[7:0] = byte_i;
          state_nxt = WAIT_HI;
        end
        WAIT_HI: begin
          hold_nxt.data[15:8] = byte_i;
          valid_nxt = 1'b1; // whole word seen, commit once [R19]
          state_nxt = IDLE_END;
        end
        IDLE_END: begin
          state_nxt = IDLE_END; // extra bytes ignored
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= WAIT_CMD;
      hold_r <= '0;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign xfer_o = hold_r;
  assign xfer_valid_o = valid_r;

endmodule

// ### rtl/pwm_cfg_regs.sv
// three 16-bit configuration words with decode to the power stage
// assumes byte strobes, enable and fault strobes share clock_i
`timescale 1ns/100ps
`include "pwm_cfg_consts.svh"
module pwm_cfg_regs
  import pwm_cfg_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYCLES = `SYNC_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic frame_start_i,
  input wire logic frame_abort_i,
  input wire logic [7:0] rd_cmd_i,
  output logic [15:0] rd_data_o,
  output logic rd_hit_o,
  input wire logic device_enabled_i,
  input wire logic sense_sample_i,
  input wire logic sense_violation_i,
  input wire logic [6:0] dt_req_hl_i,
  input wire logic [6:0] dt_req_lh_i,
  input wire logic [7:0] ramp_duty_i,
  input wire logic power_good_i,
  input wire logic sync_clk_i,
  output cfg_s cfg_o,
  output logic [6:0] dt_hl_o,
  output logic [6:0] dt_lh_o,
  output logic [7:0] ramp_duty_o,
  output logic current_fault_o,
  output logic temp_meas_en_o,
  output logic sync_run_o,
  output logic power_good_pin_o,
  output logic power_good_pin_oe_o,
  output logic sync_pin_o,
  output logic sync_pin_oe_o,
  output logic low_side_gate_out_o
);

  word_xfer_s xfer;
  logic xfer_valid;
  logic [15:0] dead_r, dead_nxt;
  logic [15:0] maker_r, maker_nxt;
  logic [15:0] user_r, user_nxt;

  // clamp a signed deadtime request to [0, limit], limit itself capped at range
  function automatic logic [6:0] clamp_dt(input logic [6:0] req, input logic [6:0] lim);
    logic [6:0] top;
    top = ($signed(lim) > $signed(`DEADTIME_RANGE_NS)) ? `DEADTIME_RANGE_NS : lim;
    if ($signed(top) < 0) top = 7'h00;
    if ($signed(req) < 0) clamp_dt = 7'h00;
    else if ($signed(req) > $signed(top)) clamp_dt = top;
    else clamp_dt = req;
  endfunction

  word_receiver u_rx (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .byte_valid_i(byte_valid_i),
    .byte_i(byte_i),
    .frame_start_i(frame_start_i),
    .frame_abort_i(frame_abort_i),
    .xfer_o(xfer),
    .xfer_valid_o(xfer_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits masked so writes never store them
  always_comb begin
    dead_nxt = dead_r;
    maker_nxt = maker_r;
    user_nxt = user_r;
    if (xfer_valid) begin // only a full word commits [R19]
      unique case (xfer.cmd)
        `CMD_DEADTIME_LIMIT: dead_nxt = xfer.data & `MASK_DEADTIME_LIMIT; // [R18]
        `CMD_MAKER_CONFIG: maker_nxt = xfer.data & `MASK_MAKER_CONFIG;
        `CMD_USER_CONFIG: user_nxt = xfer.data & `MASK_USER_CONFIG; // [R18]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dead_r <= `RST_DEADTIME_LIMIT; // 56 ns both edges [R1]
      maker_r <= `RST_MAKER_CONFIG;
      user_r <= `RST_USER_CONFIG;
    end else begin
      dead_r <= dead_nxt;
      maker_r <= maker_nxt;
      user_r <= user_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback, combinational on the command code
  always_comb begin
    rd_hit_o = 1'b1;
    unique case (rd_cmd_i)
      `CMD_DEADTIME_LIMIT: rd_data_o = dead_r;
      `CMD_MAKER_CONFIG: rd_data_o = maker_r;
      `CMD_USER_CONFIG: rd_data_o = user_r;
      default: begin
        rd_data_o = 16'h0000;
        rd_hit_o = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode
  always_comb begin
    cfg_o.dt_max_hl = dead_r[14:8]; // [R3]
    cfg_o.dt_max_lh = dead_r[6:0]; // [R4]
    cfg_o.blank_ns = 10'(maker_r[15:11] * `BLANK_STEP_NS); // [R5]
    cfg_o.fault_count = {maker_r[10:8], 1'b1}; // 2C+1 [R6]
    cfg_o.ext_temp_en = maker_r[7]; // [R7]
    cfg_o.ext_temp_sel = maker_r[6]; // [R8]
    cfg_o.sense_mode = sense_mode_e'(maker_r[5:4]); // [R9]
    cfg_o.nonlinear_response_always = maker_r[3];
    cfg_o.alt_ramp_en = maker_r[2];
    cfg_o.min_duty_en = user_r[13];
    cfg_o.min_duty_num = {1'b0, user_r[15:14]} + 3'h1; // [R11]
    cfg_o.ff_correct = ~user_r[9]; // [R13]
    cfg_o.spread_immediate = user_r[8]; // [R14]
    cfg_o.sync_external = user_r[6]; // [R15]
    cfg_o.sync_drive_out = user_r[5]; // [R15]
    cfg_o.low_side_on_disabled = user_r[2];
    cfg_o.standby_mode = standby_mode_e'(user_r[1:0]); // [R17]
  end

  // limits hold whether the request is frozen or adaptive [R2]
  assign dt_hl_o = clamp_dt(dt_req_hl_i, dead_r[14:8]);
  assign dt_lh_o = clamp_dt(dt_req_lh_i, dead_r[6:0]);

  // ramp duty floor only while enabled [R11]
  always_comb begin
    ramp_duty_o = ramp_duty_i;
    if (user_r[13] && (ramp_duty_i < {5'h00, cfg_o.min_duty_num})) begin
      ramp_duty_o = {5'h00, cfg_o.min_duty_num};
    end
  end

  // temperature: external path only when enabled [R7]; selection bit passed through as written [R8]
  assign temp_meas_en_o = maker_r[7];

  ////////////////////////////////////////////////////////////////////////
  // consecutive violation counter; a pass resets the run
  logic [3:0] viol_r, viol_nxt;
  logic fault_r, fault_nxt;

  always_comb begin
    viol_nxt = viol_r;
    fault_nxt = fault_r;
    if (sense_sample_i) begin
      if (sense_violation_i) begin
        if (viol_r != 4'hF) viol_nxt = viol_r + 4'h1;
        if ((viol_r + 4'h1) >= cfg_o.fault_count) fault_nxt = 1'b1; // [R6]
      end else begin
        viol_nxt = 4'h0;
        fault_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      viol_r <= 4'h0;
      fault_r <= 1'b0;
    end else begin
      viol_r <= viol_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign current_fault_o = fault_r;

  ////////////////////////////////////////////////////////////////////////
  // sync timeout after disable; counter saturates rather than wraps
  logic [31:0] tmo_r, tmo_nxt;
  logic sync_run_r, sync_run_nxt;

  always_comb begin
    tmo_nxt = tmo_r;
    sync_run_nxt = sync_run_r;
    if (device_enabled_i || !user_r[11]) begin
      tmo_nxt = 32'h0000_0000;
      sync_run_nxt = 1'b1; // keeps running when timeout off [R12]
    end else if (tmo_r < 32'(SYNC_TIMEOUT_CYCLES - 1)) begin
      tmo_nxt = tmo_r + 32'h0000_0001;
    end else begin
      sync_run_nxt = 1'b0; // stopped 500 ms after disable [R12]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tmo_r <= 32'h0000_0000;
      sync_run_r <= 1'b1;
    end else begin
      tmo_r <= tmo_nxt;
      sync_run_r <= sync_run_nxt;
    end
  end

  assign sync_run_o = sync_run_r;

  ////////////////////////////////////////////////////////////////////////
  // pin drive: open-drain only ever pulls low
  always_comb begin
    power_good_pin_o = power_good_i;
    power_good_pin_oe_o = maker_r[1] ? 1'b1 : ~power_good_i; // [R10]
    sync_pin_o = sync_clk_i & sync_run_r;
    // input-only sync pin never driven [R15]
    if (!user_r[5] || user_r[6]) begin
      sync_pin_oe_o = 1'b0;
    end else begin
      sync_pin_oe_o = maker_r[0] ? 1'b1 : ~sync_pin_o; // [R10]
    end
    // low side held per config while disabled [R16]
    low_side_gate_out_o = device_enabled_i ? 1'b0 : user_r[2];
  end

endmodule

// ### verif/pwm_cfg_regs_props.sv
// concurrent checks on the config bank ports
// assumes bind into pwm_cfg_regs; bench holds rd_cmd_i on D0 during fault runs
`timescale 1ns/100ps
module pwm_cfg_regs_props
  import pwm_cfg_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] rd_cmd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic device_enabled_i,
  input wire logic sense_sample_i,
  input wire logic sense_violation_i,
  input wire logic [7:0] ramp_duty_i,
  input wire logic power_good_i,
  input wire cfg_s cfg_o,
  input wire logic [6:0] dt_hl_o,
  input wire logic [6:0] dt_lh_o,
  input wire logic [7:0] ramp_duty_o,
  input wire logic current_fault_o,
  input wire logic temp_meas_en_o,
  input wire logic sync_run_o,
  input wire logic power_good_pin_o,
  input wire logic power_good_pin_oe_o,
  input wire logic low_side_gate_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  logic [31:0] off_r;
  logic [31:0] off_nxt;
  ////////////////////////////////////////////////////////////////////////////////
  // violation run and disabled time as the bank should count them
  always_comb begin
    run_nxt = sense_sample_i ? (sense_violation_i ? run_r + 8'h01 : 8'h00) : run_r;
    off_nxt = device_enabled_i ? 32'h0 : off_r + 32'h1; // no wrap within a run
  end
  always_ff @(posedge clock_i) begin
    run_r <= rst_i ? 8'h00 : run_nxt;
    off_r <= rst_i ? 32'h0 : off_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_bad;
    sense_sample_i && sense_violation_i;
  endsequence
  sequence s_clean;
    sense_sample_i && !sense_violation_i;
  endsequence
  // negative limit grants nothing, the range tops out at 60
  property p_dt(logic [6:0] o, logic [6:0] lim);
    o <= 7'h3C && (lim[6] ? o == 7'h00 : o <= lim);
  endproperty
  a_dt_hl_cap: assert property (p_dt(dt_hl_o, cfg_o.dt_max_hl))
    else $error("high-to-low deadtime above its limit");
  a_dt_lh_cap: assert property (p_dt(dt_lh_o, cfg_o.dt_max_lh))
    else $error("low-to-high deadtime above its limit");
  a_fault_on_run: assert property ((rd_cmd_i == 8'hD0 &&
    run_r + 8'h01 >= {4'h0, rd_data_o[10:8], 1'b1}) ##0 s_bad |-> ##[1:2] current_fault_o)
    else $error("fault missing after full violation run");
  a_fault_clean: assert property (s_clean |-> ##[1:2] !current_fault_o)
    else $error("fault held after clean sample");
  a_duty_floor: assert property (ramp_duty_o == ((cfg_o.min_duty_en &&
    ramp_duty_i < {5'h00, cfg_o.min_duty_num}) ? {5'h00, cfg_o.min_duty_num} : ramp_duty_i))
    else $error("ramp duty floor wrong");
  a_low_side_idle: assert property (low_side_gate_out_o ==
    (!device_enabled_i && cfg_o.low_side_on_disabled))
    else $error("low-side drive wrong");
  a_sync_hold: assert property (off_r + 32'h2 < SYNC_TIMEOUT_CYCLES |-> sync_run_o)
    else $error("sync stopped too early");
  a_pg_drive_low: assert property ($fell(power_good_i) |->
    ##[0:1] (power_good_pin_oe_o && !power_good_pin_o))
    else $error("power-good pin not pulled low");
  a_temp_enable: assert property (rd_cmd_i == 8'hD0 |-> temp_meas_en_o == rd_data_o[7])
    else $error("temperature enable not following its bit");
endmodule
bind pwm_cfg_regs pwm_cfg_regs_props #(.SYNC_TIMEOUT_CYCLES(SYNC_TIMEOUT_CYCLES)) u_props (
  .clock_i, .rst_i, .rd_cmd_i, .rd_data_o, .device_enabled_i, .sense_sample_i,
  .sense_violation_i, .ramp_duty_i, .power_good_i, .cfg_o, .dt_hl_o, .dt_lh_o,
  .ramp_duty_o, .current_fault_o, .temp_meas_en_o, .sync_run_o, .power_good_pin_o,
  .power_good_pin_oe_o, .low_side_gate_out_o
);

// ### verif/bus_host.sv
// bus host model: a word write as frame start, command, low and high byte
// assumes the bank samples bytes on the rising edge of clock_i
`timescale 1ns/100ps
module bus_host (
  input wire logic clock_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic frame_start_o,
  output logic frame_abort_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'hA5;
    frame_start_o = 1'b0;
    frame_abort_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // abort_at 0..2 kills the frame before that byte, 3 sends it whole
  task automatic send(input logic [7:0] cmd, input logic [15:0] data, input int abort_at);
    logic [7:0] b [3];
    b = '{cmd, data[7:0], data[15:8]};
    @(negedge clock_i);
    frame_start_o = 1'b1;
    @(negedge clock_i);
    frame_start_o = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // an aborted frame sends nothing more, else the tail would restart a word
      if (i == abort_at) begin
        byte_valid_o = 1'b0;
        frame_abort_o = 1'b1;
        @(negedge clock_i);
        frame_abort_o = 1'b0;
        break;
      end
      byte_valid_o = 1'b1;
      byte_o = b[i];
      @(negedge clock_i);
    end
    byte_valid_o = 1'b0;
    byte_o = ~byte_o; // released bus must not look like the last byte
    repeat (3) @(negedge clock_i);
  endtask
endmodule

// ### verif/tb_pwm_module_config_registers.sv
// self-checking bench for the config bank with the host model on its byte port
// assumes the checker binds itself; short sync timeout of 20 cycles
`timescale 1ns/100ps
module tb_pwm_module_config_registers
  import pwm_cfg_pkg::*;
;
  `define CHK(got, exp) \
    begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
        bad_count++; \
        $display("unexpected at %0t: got %h want %h", $time, got, exp); \
      end \
    end
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] wr;
    logic [15:0] rd;
    logic hit;
  } row_s;
  row_s rows [7] = '{'{8'hBF, 16'hFFFF, 16'h7F7F, 1'b1}, '{8'hD0, 16'hFFFF, 16'hFFFF, 1'b1},
    '{8'hD1, 16'hFFFF, 16'hEB67, 1'b1}, '{8'hBF, 16'h3C3C, 16'h3C3C, 1'b1},
    '{8'hD1, 16'h2011, 16'h2001, 1'b1}, '{8'hD0, 16'h6A11, 16'h6A11, 1'b1},
    '{8'hD2, 16'h1234, 16'h0000, 1'b0}};
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic byte_valid, frame_start, frame_abort, rd_hit_o, current_fault_o, sync_run_o;
  logic low_side_gate_out_o;
  logic temp_meas_en_o, power_good_pin_o, power_good_pin_oe_o, sync_pin_o, sync_pin_oe_o;
  logic [7:0] byte_b;
  logic [7:0] rd_cmd_i = 8'h00;
  logic [15:0] rd_data_o;
  logic device_enabled_i = 1'b0;
  logic sense_sample_i = 1'b0;
  logic sense_violation_i = 1'b0;
  logic [6:0] dt_req_hl_i = 7'h00;
  logic [6:0] dt_req_lh_i = 7'h00;
  logic [6:0] dt_hl_o, dt_lh_o;
  logic [7:0] ramp_duty_i = 8'h00;
  logic [7:0] ramp_duty_o;
  logic power_good_i = 1'b0;
  logic sync_clk_i = 1'b0;
  cfg_s cfg_o;
  ////////////////////////////////////////////////////////////////////////////////
  bus_host host (.clock_i(clock_i), .byte_valid_o(byte_valid), .byte_o(byte_b),
    .frame_start_o(frame_start), .frame_abort_o(frame_abort));
  pwm_cfg_regs #(.SYNC_TIMEOUT_CYCLES(20)) DUT (.clock_i(clock_i), .rst_i(rst_i),
    .byte_valid_i(byte_valid), .byte_i(byte_b), .frame_start_i(frame_start),
    .frame_abort_i(frame_abort), .rd_cmd_i(rd_cmd_i), .rd_data_o(rd_data_o),
    .rd_hit_o(rd_hit_o), .device_enabled_i(device_enabled_i),
    .sense_sample_i(sense_sample_i), .sense_violation_i(sense_violation_i),
    .dt_req_hl_i(dt_req_hl_i), .dt_req_lh_i(dt_req_lh_i), .ramp_duty_i(ramp_duty_i),
    .power_good_i(power_good_i), .sync_clk_i(sync_clk_i), .cfg_o(cfg_o),
    .dt_hl_o(dt_hl_o), .dt_lh_o(dt_lh_o), .ramp_duty_o(ramp_duty_o),
    .current_fault_o(current_fault_o), .temp_meas_en_o(temp_meas_en_o),
    .sync_run_o(sync_run_o), .power_good_pin_o(power_good_pin_o),
    .power_good_pin_oe_o(power_good_pin_oe_o), .sync_pin_o(sync_pin_o),
    .sync_pin_oe_o(sync_pin_oe_o),
    .low_side_gate_out_o(low_side_gate_out_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    rd_cmd_i = cmd;
    #1;
    `CHK(rd_data_o, exp)
  endtask
  task automatic samp(input logic v);
    sense_violation_i = v;
    sense_sample_i = 1'b1;
    @(negedge clock_i);
    sense_sample_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic dt(input logic [6:0] hl, lh, hl_exp, lh_exp);
    dt_req_hl_i = hl;
    dt_req_lh_i = lh;
    #1;
    `CHK({dt_hl_o, dt_lh_o}, {hl_exp, lh_exp})
  endtask
  task automatic duty(input logic [7:0] req, exp);
    ramp_duty_i = req;
    #1;
    `CHK(ramp_duty_o, exp)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clock_i = ~clock_i;
  // status inputs keep moving; cycle ceiling cuts a hang short
  always @(negedge clock_i) begin
    cyc <= cyc + 1;
    power_good_i <= cyc[2];
    sync_clk_i <= cyc[0];
    if (cyc == 1500) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    rd(8'hBF, 16'h3838);
    rd(8'hD0, 16'h6A11);
    rd(8'hD1, 16'h2011);
    foreach (rows[i]) begin
      host.send(rows[i].cmd, rows[i].wr, 3);
      rd(rows[i].cmd, rows[i].rd);
      `CHK(rd_hit_o, rows[i].hit)
    end
    for (int a = 0; a < 3; a++) begin
      host.send(8'hBF, 16'h0101, a);
      rd(8'hBF, 16'h3C3C);
    end
    for (int i = 0; i < 4; i++) begin
      host.send(8'hD0, 16'h00C0 | (16'(i) << 4), 3);
      host.send(8'hD1, 16'h0020 | 16'(i), 3);
      `CHK(cfg_o.sense_mode, 2'(i))
      `CHK(cfg_o.standby_mode, 2'(i))
      // open-drain pins, settle past the status update at this edge
      #1;
      `CHK({power_good_pin_oe_o, power_good_pin_o}, {~power_good_i, power_good_i})
      `CHK({sync_pin_oe_o, sync_pin_o}, {~sync_clk_i, sync_clk_i})
      `CHK({cfg_o.ext_temp_sel, temp_meas_en_o}, 2'b11)
    end
    // push-pull pins, longest blanking, feed-forward off, immediate spreading
    host.send(8'hD0, 16'hF803, 3);
    host.send(8'hD1, 16'h0320, 3);
    #1;
    `CHK(cfg_o.blank_ns, 10'h3E0)
    `CHK({cfg_o.ff_correct, cfg_o.spread_immediate, temp_meas_en_o}, 3'b010)
    `CHK({power_good_pin_oe_o, power_good_pin_o}, {1'b1, power_good_i})
    `CHK({sync_pin_oe_o, sync_pin_o}, {1'b1, sync_clk_i})
    host.send(8'hD1, 16'h0060, 3);
    #1;
    `CHK({cfg_o.ff_correct, cfg_o.spread_immediate}, 2'b10)
    `CHK({cfg_o.sync_external, sync_pin_oe_o}, 2'b10)
    host.send(8'hD1, 16'h0000, 3);
    #1;
    `CHK(sync_pin_oe_o, 1'b0)
    host.send(8'hD0, 16'h0100, 3);
    rd_cmd_i = 8'hD0;
    samp(1'b1);
    samp(1'b1);
    `CHK(current_fault_o, 1'b0)
    samp(1'b1);
    `CHK(current_fault_o, 1'b1)
    samp(1'b0);
    `CHK(current_fault_o, 1'b0)
    host.send(8'hBF, 16'h1410, 3);
    dt(7'h1E, 7'h7B, 7'h14, 7'h00);
    dt(7'h05, 7'h0A, 7'h05, 7'h0A);
    host.send(8'hBF, 16'h3F3F, 3);
    dt(7'h3E, 7'h3F, 7'h3C, 7'h3C);
    host.send(8'hD1, 16'hE000, 3);
    duty(8'h01, 8'h04);
    duty(8'h09, 8'h09);
    host.send(8'hD1, 16'hC000, 3);
    duty(8'h01, 8'h01);
    host.send(8'hD1, 16'h0804, 3);
    device_enabled_i = 1'b1;
    repeat (3) @(negedge clock_i);
    `CHK({sync_run_o, low_side_gate_out_o}, 2'b10)
    device_enabled_i = 1'b0;
    repeat (10) @(negedge clock_i);
    `CHK({sync_run_o, low_side_gate_out_o}, 2'b11)
    repeat (15) @(negedge clock_i);
    `CHK(sync_run_o, 1'b0)
    host.send(8'hD1, 16'h0004, 3);
    repeat (25) @(negedge clock_i);
    `CHK(sync_run_o, 1'b1)
    samp(1'b1);
    samp(1'b1);
    samp(1'b1);
    `CHK(current_fault_o, 1'b1)
    // mid-run reset must restore defaults and drop the fault
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK(current_fault_o, 1'b0)
    rd(8'hBF, 16'h3838);
    rd(8'hD0, 16'h6A11);
    rd(8'hD1, 16'h2011);
    give_verdict();
  end
endmodule
